// *** mmc_pkg.sv ***
// How it works
// R1: mask2 bits 0,1,4 block their interrupt
// R2: mask2 bit 7 gates the reset pulse
// R3: mask2 powers up zero, fully read/write
// R4: compatibility register is plain storage, reset zero
// R5: case-clear bit pulses pin low, self-clears
// R6: low voltage-code bits read pins, ignore writes
// R7: bits 5:4 pick fan one prescale
// R8: bits 7:6 pick fan two prescale
// R9: 7-bit address, low bits strapped, bit7 read-only
// R10: bit0 high code pin, bits 7:1 fixed id
// R11: temperature config powers up as 01h
// R12: default mode re-flags each hot conversion
// R13: one-time mode flags once per excursion
// R14: comparator mode follows hot limit, no hysteresis
// R15: status read clears the returned conditions
// R16: reset request gives long active-low pulse
// R17: restore-defaults reloads masks, prescales, temp config
// R18: interrupt asserts for unmasked status when enabled
`default_nettype none
package mmc_pkg;
    localparam logic [7:0] OFS_STATUS_ONE   = 8'h41;
    localparam logic [7:0] OFS_STATUS_TWO   = 8'h42;
    localparam logic [7:0] OFS_MASK_TWO     = 8'h44;
    localparam logic [7:0] OFS_COMPAT       = 8'h45;
    localparam logic [7:0] OFS_CASE_CLEAR   = 8'h46;
    localparam logic [7:0] OFS_VCODE_FAN    = 8'h47;
    localparam logic [7:0] OFS_SERIAL_ADDR  = 8'h48;
    localparam logic [7:0] OFS_VCODE_IDENT  = 8'h49;
    localparam logic [7:0] OFS_TEMP_CONFIG  = 8'h4b;

    localparam logic [7:0] RST_MASK_TWO     = 8'h00;
    localparam logic [7:0] RST_COMPAT       = 8'h00;
    localparam logic [3:0] RST_FAN_PRESCALE = 4'h5;
    localparam logic [7:0] RST_TEMP_CONFIG  = 8'h01;
    localparam logic [4:0] RST_ADDR_UPPER   = 5'h0b;
    // arbitrary identification value
    localparam logic [6:0] IDENT_VALUE      = 7'h15;
    localparam logic [7:0] STATUS_TWO_USED  = 8'h13;

    localparam int BIT_RAIL12     = 0;
    localparam int BIT_CPU_RAIL2  = 1;
    localparam int BIT_CASE_OPEN  = 4;
    localparam int BIT_RESET_EN   = 7;
    localparam int BIT_CASE_CLEAR = 7;
    localparam int FAN_ONE_LSB    = 4;
    localparam int FAN_TWO_LSB    = 6;

    localparam logic [2:0] STRAP_WAIT = 3'h5;
    localparam int unsigned PULSE_MS    = 20;
    localparam int unsigned CLK_MHZ     = 250;
    localparam int unsigned PULSE_CYCLES = PULSE_MS * CLK_MHZ * 1000;

    typedef enum logic [1:0] {
        MMC_TMODE_DEF0 = 2'b00,
        MMC_TMODE_ONCE = 2'b01,
        MMC_TMODE_CMP  = 2'b10,
        MMC_TMODE_DEF1 = 2'b11
    } mmc_tmode_t;
endpackage
`default_nettype wire

// *** mmc_pulse_timer.sv ***
`default_nettype none
module mmc_pulse_timer #(
    parameter int unsigned CYCLES = 8
) (
    input  wire logic ref_clk,
    input  wire logic rst_n,
    input  wire logic start,
    output var  logic active,
    output var  logic done
);
    logic [31:0] count;

    // start is ignored while a pulse runs, so a pulse is never cut short
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            active <= 1'b0;
            count  <= 32'h0;
            done   <= 1'b0;
        end else if (!active) begin
            done   <= 1'b0;
            active <= start;
            count  <= 32'h0;
        end else begin
            count  <= count + 32'h1;
            if (count == CYCLES - 1) begin
                active <= 1'b0;
                done   <= 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

// *** mmc_regs.sv ***
`default_nettype none
module mmc_regs #(
    parameter int unsigned PULSE_LEN = mmc_pkg::PULSE_CYCLES
) (
    input  wire logic       ref_clk,
    input  wire logic       rst_n,
    input  wire logic [7:0] reg_addr,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    input  wire logic [7:0] reg_wdata,
    output var  logic [7:0] reg_rdata,
    input  wire logic [3:0] core_voltage_code,
    input  wire logic       core_voltage_code_high,
    input  wire logic       addr_strap_low,
    input  wire logic       addr_strap_high,
    input  wire logic       case_open_i,
    output var  logic       case_open_o,
    output var  logic       case_open_oe_n,
    output var  logic       sys_reset_o,
    output var  logic       sys_reset_oe_n,
    output var  logic       sys_reset_ack,
    input  wire logic       cfg_int_enable,
    input  wire logic       cfg_reset_req,
    input  wire logic       cfg_case_clear_req,
    input  wire logic       cfg_init,
    input  wire logic       rail12_err,
    input  wire logic       cpu_rail_two_err,
    input  wire logic       mask_one_temp,
    input  wire logic       conv_done,
    input  wire logic       temp_above_hot,
    input  wire logic       temp_below_hyst,
    output var  logic       temp_flag,
    output var  logic [3:0] fan_one_prescale,
    output var  logic [3:0] fan_two_prescale,
    output var  logic [6:0] serial_addr,
    output var  logic       int_n
);
    import mmc_pkg::*;

    function automatic logic [3:0] prescale_div(input logic [1:0] code);
        prescale_div = 4'h1 << code;
    endfunction

    logic [7:0] int_mask_two;
    logic [7:0] compat_reserved;
    logic       case_clear;
    logic [3:0] fan_bits;
    logic [6:0] addr_reg;
    logic [7:0] temp_irq_config;
    logic [7:0] status_two;
    logic [7:0] sync1;
    logic [7:0] sync2;
    logic [7:0] sync3;
    logic [7:0] pin_f;
    logic       case_prev;
    logic       hot_latched;
    logic [2:0] strap_cnt;
    logic       strap_done;
    logic       case_active;
    logic       case_done;
    logic       rst_active;
    logic       rst_start;
    logic       case_start;
    logic       wr_hit_addr;
    mmc_tmode_t tmode;

    assign tmode      = mmc_tmode_t'(temp_irq_config[1:0]);
    assign rst_start  = cfg_reset_req && int_mask_two[BIT_RESET_EN] && !rst_active; // R2 R16
    assign case_start = case_clear && !case_active && !case_done; // R5
    assign wr_hit_addr = reg_wr && (reg_addr == OFS_SERIAL_ADDR);

    // pins pass three flops; a change counts once the last two agree
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_pin
            logic pin_raw;
            if (gi < 4) begin : g_low
                assign pin_raw = core_voltage_code[gi];
            end else if (gi == 4) begin : g_high
                assign pin_raw = core_voltage_code_high;
            end else if (gi == 5) begin : g_sl
                assign pin_raw = addr_strap_low;
            end else if (gi == 6) begin : g_sh
                assign pin_raw = addr_strap_high;
            end else begin : g_case
                assign pin_raw = case_open_i;
            end
            always_ff @(posedge ref_clk) begin
                if (!rst_n) begin
                    sync1[gi] <= 1'b0;
                    sync2[gi] <= 1'b0;
                    sync3[gi] <= 1'b0;
                    pin_f[gi] <= 1'b0;
                end else begin
                    sync1[gi] <= pin_raw;
                    sync2[gi] <= sync1[gi];
                    sync3[gi] <= sync2[gi];
                    if (sync2[gi] == sync3[gi]) begin
                        pin_f[gi] <= sync3[gi];
                    end
                end
            end
        end
    endgenerate

    mmc_pulse_timer #(.CYCLES(PULSE_LEN)) u_case_timer (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .start   (case_start || cfg_case_clear_req),
        .active  (case_active),
        .done    (case_done)
    );

    mmc_pulse_timer #(.CYCLES(PULSE_LEN)) u_reset_timer (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .start   (rst_start),
        .active  (rst_active),
        .done    ()
    );

    // open-drain style: drive low only while a pulse runs
    always_comb begin
        case_open_o    = 1'b0;
        case_open_oe_n = !case_active; // R5
        sys_reset_o    = 1'b0;
        sys_reset_oe_n = !rst_active; // R16
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            sys_reset_ack <= 1'b0;
        end else begin
            sys_reset_ack <= rst_start; // R16
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n || cfg_init) begin
            int_mask_two    <= RST_MASK_TWO; // R3 R17
            fan_bits        <= RST_FAN_PRESCALE; // R17
            temp_irq_config <= RST_TEMP_CONFIG; // R11 R17
        end else if (reg_wr) begin
            if (reg_addr == OFS_MASK_TWO) begin
                int_mask_two <= reg_wdata; // R3
            end
            if (reg_addr == OFS_VCODE_FAN) begin
                fan_bits <= reg_wdata[7:4]; // R7 R8
            end
            if (reg_addr == OFS_TEMP_CONFIG) begin
                temp_irq_config <= reg_wdata;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            compat_reserved <= RST_COMPAT; // R4
        end else if (reg_wr && reg_addr == OFS_COMPAT) begin
            compat_reserved <= reg_wdata; // R4
        end
    end

    // a write of one wins over the self-clear in the same cycle
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            case_clear <= 1'b0;
        end else if (reg_wr && reg_addr == OFS_CASE_CLEAR && reg_wdata[BIT_CASE_CLEAR]) begin
            case_clear <= 1'b1; // R5
        end else if (case_done) begin
            case_clear <= 1'b0; // R5
        end
    end

    // straps are caught after reset once the synchronisers have settled
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            addr_reg   <= {RST_ADDR_UPPER, 2'b00};
            strap_cnt  <= 3'h0;
            strap_done <= 1'b0;
        end else begin
            if (strap_cnt != STRAP_WAIT) begin
                strap_cnt <= strap_cnt + 3'h1;
            end
            if (wr_hit_addr) begin
                addr_reg   <= reg_wdata[6:0]; // R9
                strap_done <= 1'b1;
            end else if (!strap_done && strap_cnt == STRAP_WAIT) begin
                addr_reg[1:0] <= {pin_f[6], pin_f[5]}; // R9
                strap_done    <= 1'b1;
            end
        end
    end

    // case-open edges are ignored while we pull the pin ourselves
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            case_prev  <= 1'b0;
            status_two <= 8'h00;
        end else begin
            case_prev <= pin_f[7];
            if (cfg_init) begin
                status_two <= 8'h00; // R17
            end else begin
                status_two[BIT_RAIL12] <= rail12_err ||
                    (status_two[BIT_RAIL12] && !(reg_rd && reg_addr == OFS_STATUS_TWO)); // R15
                status_two[BIT_CPU_RAIL2] <= cpu_rail_two_err ||
                    (status_two[BIT_CPU_RAIL2] && !(reg_rd && reg_addr == OFS_STATUS_TWO)); // R15
                status_two[BIT_CASE_OPEN] <= (pin_f[7] && !case_prev && !case_active) ||
                    (status_two[BIT_CASE_OPEN] && !(reg_rd && reg_addr == OFS_STATUS_TWO)); // R15
            end
        end
    end

    // hot_latched: above hot seen and not yet back below hysteresis
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            hot_latched <= 1'b0;
            temp_flag   <= 1'b0;
        end else begin
            if (conv_done) begin
                if (temp_above_hot) begin
                    hot_latched <= 1'b1;
                end else if (temp_below_hyst) begin
                    hot_latched <= 1'b0;
                end
            end
            case (tmode)
                MMC_TMODE_CMP: begin
                    if (conv_done) begin
                        temp_flag <= temp_above_hot; // R14
                    end
                end
                MMC_TMODE_ONCE: begin
                    if (conv_done && temp_above_hot && !hot_latched) begin
                        temp_flag <= 1'b1; // R13
                    end else if (reg_rd && reg_addr == OFS_STATUS_ONE) begin
                        temp_flag <= 1'b0; // R13 R15
                    end
                end
                default: begin
                    if (conv_done && (temp_above_hot || (hot_latched && !temp_below_hyst))) begin
                        temp_flag <= 1'b1; // R12
                    end else if (reg_rd && reg_addr == OFS_STATUS_ONE) begin
                        temp_flag <= 1'b0; // R12 R15
                    end
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            int_n <= 1'b1;
        end else begin
            int_n <= !(cfg_int_enable &&
                ((|(status_two & ~int_mask_two & STATUS_TWO_USED)) ||
                 (temp_flag && !mask_one_temp))); // R1 R18
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            case (reg_addr)
                OFS_STATUS_TWO:  reg_rdata <= status_two;
                OFS_MASK_TWO:    reg_rdata <= int_mask_two;
                OFS_COMPAT:      reg_rdata <= compat_reserved;
                OFS_CASE_CLEAR:  reg_rdata <= {case_clear, 7'h00};
                OFS_VCODE_FAN:   reg_rdata <= {fan_bits, pin_f[3:0]}; // R6
                OFS_SERIAL_ADDR: reg_rdata <= {1'b0, addr_reg}; // R9
                OFS_VCODE_IDENT: reg_rdata <= {IDENT_VALUE, pin_f[4]}; // R10
                OFS_TEMP_CONFIG: reg_rdata <= temp_irq_config;
                default:         reg_rdata <= 8'h00;
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            // both prescale fields power up as 01, divide by two
            fan_one_prescale <= 4'h2;
            fan_two_prescale <= 4'h2;
            serial_addr      <= 7'h00;
        end else begin
            fan_one_prescale <= prescale_div(fan_bits[FAN_ONE_LSB-4 +: 2]); // R7
            fan_two_prescale <= prescale_div(fan_bits[FAN_TWO_LSB-4 +: 2]); // R8
            serial_addr      <= addr_reg;
        end
    end

    // helper: length of the case-open pulse, checked when it ends
    logic [31:0] case_len;
    always_ff @(posedge ref_clk) begin
        if (!rst_n || !case_active) begin
            case_len <= 32'h0;
        end else begin
            case_len <= case_len + 32'h1;
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    chk_int_enable_gate: assert property (!int_n |-> $past(cfg_int_enable)) // R18
        else $error("interrupt asserted while disabled");
    chk_mask_blocks_int: assert property ((status_two != 8'h00 && !temp_flag // R1
        && (status_two & ~int_mask_two) == 8'h00) |=> int_n)
        else $error("masked status drove interrupt");
    chk_reset_gated: assert property ((cfg_reset_req && !int_mask_two[BIT_RESET_EN]
        && !rst_active) |=> sys_reset_oe_n) // R2
        else $error("reset pulse while disabled");
    chk_case_pulse_len: assert property ($fell(case_active) // R5
        |-> $past(case_len) == PULSE_LEN - 1)
        else $error("case-open pulse length wrong");
    chk_case_pulse_start: assert property ((reg_wr && reg_addr == OFS_CASE_CLEAR // R5
        && reg_wdata[7] && !case_clear && !case_active && !case_done) |=> ##1 !case_open_oe_n)
        else $error("case-open pulse did not start");
    chk_vcode_readback: assert property ((reg_rd && reg_addr == OFS_VCODE_FAN)
        |=> reg_rdata[3:0] == $past(pin_f[3:0])) // R6
        else $error("voltage code readback wrong");
    chk_compat_store: assert property ((reg_wr && reg_addr == OFS_COMPAT && !cfg_init)
        |=> compat_reserved == $past(reg_wdata)) // R4
        else $error("compat register not stored");
    chk_init_restore: assert property (cfg_init |=> int_mask_two == RST_MASK_TWO
        && temp_irq_config == RST_TEMP_CONFIG && fan_bits == RST_FAN_PRESCALE) // R17
        else $error("restore defaults failed");
    chk_comparator_release: assert property ((tmode == MMC_TMODE_CMP && conv_done
        && !temp_above_hot) |=> !temp_flag) // R14
        else $error("comparator flag held below limit");
    chk_onetime_quiet: assert property ((tmode == MMC_TMODE_ONCE && hot_latched && !temp_flag)
        |=> !temp_flag) // R13
        else $error("one-time mode flagged twice");
    chk_status_read_clear: assert property ((reg_rd && reg_addr == OFS_STATUS_TWO // R15
        && !rail12_err && !cpu_rail_two_err && !(pin_f[7] && !case_prev)) |=> status_two == 8'h00)
        else $error("status not cleared by read");
    chk_addr_top_zero: assert property ((reg_rd && reg_addr == OFS_SERIAL_ADDR)
        |=> reg_rdata[7] == 1'b0) // R9
        else $error("address bit 7 not zero");

    cov_case_pulse: cover property ($fell(case_active));
    cov_reset_pulse: cover property ($rose(rst_active));
    cov_temp_int: cover property (temp_flag && !int_n);
endmodule
`default_nettype wire

// *** mmc_host_model.sv ***
`default_nettype none
// register-port master standing in for the bus engine; one byte per strobe
module mmc_host_model (
    input  wire logic       ref_clk,
    output var  logic [7:0] reg_addr,
    output var  logic       reg_wr,
    output var  logic       reg_rd,
    output var  logic [7:0] reg_wdata,
    input  wire logic [7:0] reg_rdata
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        reg_addr  = 8'h00;
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
        reg_wdata = 8'h00;
    end

    // address and data are inverted once released so stale values never look valid
    task automatic wr(input logic [7:0] addr, input logic [7:0] data);
        @(negedge ref_clk);
        reg_addr  = addr;
        reg_wdata = data;
        reg_wr    = 1'b1;
        @(negedge ref_clk);
        reg_wr    = 1'b0;
        reg_addr  = ~addr;
        reg_wdata = ~data;
    endtask

    // a status read also clears the status it returns, so callers read only on purpose
    task automatic rd(input logic [7:0] addr, output logic [7:0] data);
        @(negedge ref_clk);
        reg_addr = addr;
        reg_rd   = 1'b1;
        @(negedge ref_clk);
        reg_rd   = 1'b0;
        reg_addr = ~addr;
        data     = reg_rdata;
    endtask
endmodule
`default_nettype wire

// *** mmc_tb.sv ***
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import mmc_pkg::*;

    logic ref_clk = 1'b0, rst_n = 1'b0, case_ext = 1'b0, core_voltage_code_high = 1'b1;
    logic [3:0] core_voltage_code = 4'h0;
    logic cfg_int_enable = 1'b0, cfg_reset_req = 1'b0, cfg_init = 1'b0;
    logic cfg_case_clear_req = 1'b0, mask_one_temp = 1'b0;
    logic rail12_err = 1'b0, cpu_rail_two_err = 1'b0, conv_done = 1'b0;
    logic temp_above_hot = 1'b0, temp_below_hyst = 1'b0;
    logic [7:0] reg_addr, reg_wdata, reg_rdata;
    logic reg_wr, reg_rd, case_open_o, case_open_oe_n, sys_reset_o, sys_reset_oe_n;
    logic sys_reset_ack, temp_flag, int_n;
    logic [3:0] fan_one_prescale, fan_two_prescale;
    logic [6:0] serial_addr;
    wire case_open_i;
    int n_errors = 0, check_count = 0, case_low = 0, rst_low = 0, ack_cnt = 0;

    always #2 ref_clk = ~ref_clk;
    // the pin is pulled to the outside level unless the block drives it
    assign case_open_i = case_open_oe_n ? case_ext : case_open_o;

    mmc_host_model host (.ref_clk(ref_clk), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));

    // pulse length shortened from 20 ms so the run stays short
    mmc_regs #(.PULSE_LEN(16)) DUT (.ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .core_voltage_code(core_voltage_code), .core_voltage_code_high(core_voltage_code_high),
        .addr_strap_low(1'b0), .addr_strap_high(1'b1), .case_open_i(case_open_i),
        .case_open_o(case_open_o), .case_open_oe_n(case_open_oe_n), .sys_reset_o(sys_reset_o),
        .sys_reset_oe_n(sys_reset_oe_n), .sys_reset_ack(sys_reset_ack),
        .cfg_int_enable(cfg_int_enable), .cfg_reset_req(cfg_reset_req),
        .cfg_case_clear_req(cfg_case_clear_req), .cfg_init(cfg_init), .rail12_err(rail12_err),
        .cpu_rail_two_err(cpu_rail_two_err), .mask_one_temp(mask_one_temp),
        .conv_done(conv_done),
        .temp_above_hot(temp_above_hot), .temp_below_hyst(temp_below_hyst),
        .temp_flag(temp_flag), .fan_one_prescale(fan_one_prescale),
        .fan_two_prescale(fan_two_prescale), .serial_addr(serial_addr), .int_n(int_n));

    always @(posedge ref_clk) begin
        if (case_open_oe_n === 1'b0) case_low <= case_low + 1;
        if (sys_reset_oe_n === 1'b0) rst_low <= rst_low + 1;
        if (sys_reset_ack === 1'b1) ack_cnt <= ack_cnt + 1;
    end

    task automatic final_report;
        $display("checks=%0d errors=%0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk1(input logic got, input logic exp);
        check_count++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge ref_clk);
    endtask

    task automatic rd_chk(input logic [7:0] addr, input logic [7:0] exp);
        logic [7:0] d;
        host.rd(addr, d);
        chk(d, exp);
    endtask

    task automatic ev(input int k);
        @(negedge ref_clk);
        case (k)
            0: rail12_err = 1'b1;
            1: cpu_rail_two_err = 1'b1;
            2: cfg_reset_req = 1'b1;
            3: cfg_case_clear_req = 1'b1;
            default: cfg_init = 1'b1;
        endcase
        @(negedge ref_clk);
        {rail12_err, cpu_rail_two_err, cfg_reset_req, cfg_case_clear_req, cfg_init} = 5'h00;
    endtask

    // case-open events go through the pin filter, so give them time to land
    task automatic raise(input int b);
        if (b == 4) begin
            @(negedge ref_clk);
            case_ext = 1'b1;
            cyc(12);
            case_ext = 1'b0;
        end else begin
            ev(b);
        end
        cyc(12);
    endtask

    task automatic conv(input logic above, input logic below, input logic exp);
        @(negedge ref_clk);
        temp_above_hot  = above;
        temp_below_hyst = below;
        conv_done       = 1'b1;
        @(negedge ref_clk);
        conv_done = 1'b0;
        @(negedge ref_clk);
        chk1(temp_flag, exp);
    endtask

    task automatic t_reset_values;
        rd_chk(OFS_MASK_TWO, 8'h00);
        rd_chk(OFS_COMPAT, 8'h00);
        rd_chk(OFS_CASE_CLEAR, 8'h00);
        rd_chk(OFS_TEMP_CONFIG, 8'h01);
        rd_chk(OFS_SERIAL_ADDR, 8'h2e);
        chk({1'b0, serial_addr}, 8'h2e);
        chk({fan_two_prescale, fan_one_prescale}, 8'h22);
        rd_chk(OFS_VCODE_IDENT, {IDENT_VALUE, 1'b1});
    endtask

    task automatic t_rw_access;
        host.wr(OFS_MASK_TWO, 8'h6c);
        rd_chk(OFS_MASK_TWO, 8'h6c);
        host.wr(OFS_COMPAT, 8'ha5);
        rd_chk(OFS_COMPAT, 8'ha5);
        host.wr(OFS_SERIAL_ADDR, 8'hd3);
        rd_chk(OFS_SERIAL_ADDR, 8'h53);
        chk({1'b0, serial_addr}, 8'h53);
        host.wr(OFS_VCODE_IDENT, 8'h00);
        core_voltage_code_high = 1'b0;
        cyc(10);
        rd_chk(OFS_VCODE_IDENT, {IDENT_VALUE, 1'b0});
        rd_chk(8'h50, 8'h00);
        host.wr(OFS_MASK_TWO, 8'h00);
    endtask

    task automatic t_vcode_fan;
        core_voltage_code = 4'ha;
        cyc(10);
        for (int i = 0; i < 4; i++) begin
            host.wr(OFS_VCODE_FAN, {2'(3 - i), 2'(i), 4'h5});
            cyc(2);
            chk({fan_two_prescale, fan_one_prescale}, {4'(8 >> i), 4'(1 << i)});
            rd_chk(OFS_VCODE_FAN, {2'(3 - i), 2'(i), 4'ha});
        end
    endtask

    task automatic t_case_pulse;
        int s;
        s = case_low;
        host.wr(OFS_CASE_CLEAR, 8'h7f);
        rd_chk(OFS_CASE_CLEAR, 8'h00);
        host.wr(OFS_CASE_CLEAR, 8'h80);
        rd_chk(OFS_CASE_CLEAR, 8'h80);
        // a second start mid-pulse must not stretch it
        host.wr(OFS_CASE_CLEAR, 8'h80);
        cyc(24);
        chk(8'(case_low - s), 8'h10);
        rd_chk(OFS_CASE_CLEAR, 8'h00);
        // the config-side request starts the same pulse without the register bit
        ev(3);
        cyc(24);
        chk(8'(case_low - s), 8'h20);
    endtask

    task automatic t_reset_pulse;
        int s;
        int a;
        s = rst_low;
        a = ack_cnt;
        ev(2);
        cyc(24);
        chk(8'(rst_low - s), 8'h00);
        host.wr(OFS_MASK_TWO, 8'h80);
        ev(2);
        cyc(24);
        chk(8'(rst_low - s), 8'h10);
        chk(8'(ack_cnt - a), 8'h01);
        host.wr(OFS_MASK_TWO, 8'h00);
    endtask

    task automatic t_mask_irq;
        int b;
        ev(0);
        cyc(4);
        chk1(int_n, 1'b1);
        cfg_int_enable = 1'b1;
        cyc(3);
        chk1(int_n, 1'b0);
        rd_chk(OFS_STATUS_TWO, 8'h01);
        cyc(3);
        chk1(int_n, 1'b1);
        rd_chk(OFS_STATUS_TWO, 8'h00);
        for (int k = 0; k < 3; k++) begin
            b = (k == 2) ? 4 : k;
            host.wr(OFS_MASK_TWO, 8'h01 << b);
            raise(b);
            chk1(int_n, 1'b1);
            rd_chk(OFS_STATUS_TWO, 8'h01 << b);
            host.wr(OFS_MASK_TWO, 8'h00);
            raise(b);
            chk1(int_n, 1'b0);
            rd_chk(OFS_STATUS_TWO, 8'h01 << b);
            cyc(3);
            chk1(int_n, 1'b1);
        end
    endtask

    task automatic t_temp_modes;
        logic [7:0] d;
        mmc_tmode_t m;
        for (int i = 0; i < 4; i++) begin
            m = mmc_tmode_t'(i);
            host.wr(OFS_TEMP_CONFIG, {6'h00, m});
            host.rd(OFS_STATUS_ONE, d);
            conv(1'b0, 1'b1, 1'b0);
            conv(1'b1, 1'b0, 1'b1);
            cyc(1);
            chk1(int_n, 1'b0);
            mask_one_temp = 1'b1;
            cyc(2);
            chk1(int_n, 1'b1);
            mask_one_temp = 1'b0;
            host.rd(OFS_STATUS_ONE, d);
            cyc(1);
            chk1(temp_flag, m == MMC_TMODE_CMP);
            conv(1'b1, 1'b0, m != MMC_TMODE_ONCE);
            // cleared first outside comparator mode, so the below-hysteresis step must not raise it again
            host.rd(OFS_STATUS_ONE, d);
            conv(1'b0, 1'b1, 1'b0);
            conv(1'b1, 1'b0, 1'b1);
            conv(1'b0, 1'b0, m != MMC_TMODE_CMP);
        end
    endtask

    task automatic t_restore;
        host.wr(OFS_MASK_TWO, 8'hff);
        host.wr(OFS_TEMP_CONFIG, 8'h02);
        host.wr(OFS_VCODE_FAN, 8'hf0);
        ev(5);
        cyc(2);
        rd_chk(OFS_MASK_TWO, 8'h00);
        rd_chk(OFS_TEMP_CONFIG, 8'h01);
        chk({fan_two_prescale, fan_one_prescale}, 8'h22);
    endtask

    // the whole sequence needs well under a thousand cycles; this bound is generous
    initial begin
        repeat (20000) @(posedge ref_clk);
        n_errors++;
        final_report();
    end

    initial begin
        cyc(4);
        rst_n = 1'b1;
        cyc(10);
        t_reset_values();
        t_rw_access();
        t_vcode_fan();
        t_case_pulse();
        t_reset_pulse();
        t_mask_irq();
        t_temp_modes();
        t_restore();
        final_report();
    end
endmodule
`default_nettype wire
